// [hw/sfspi_regs.svh]
// constants of the serial flash command front end
`ifndef SFSPI_REGS_SVH
`define SFSPI_REGS_SVH

// opcodes taken by the front end
`define SFSPI_OP_READ 8'h03
`define SFSPI_OP_READ_FAST 8'h0B
`define SFSPI_OP_READ_DUAL 8'h3B
`define SFSPI_OP_READ_QUAD 8'h6B
`define SFSPI_OP_ERASE_4K 8'h20
`define SFSPI_OP_ERASE_32K 8'h52
`define SFSPI_OP_ERASE_64K 8'hD8
`define SFSPI_OP_ERASE_CHIP_A 8'h60
`define SFSPI_OP_ERASE_CHIP_B 8'hC7
`define SFSPI_OP_PROGRAM 8'h02
`define SFSPI_OP_WREN 8'h06
`define SFSPI_OP_WRDI 8'h04

// last edge index of each frame field, one less than its length in serial clock edges
`define SFSPI_OPCODE_LAST 5'h07
`define SFSPI_ADDR_LAST 5'h17
`define SFSPI_DUMMY_LAST 5'h07
`define SFSPI_BYTE_LAST 5'h07

// array geometry, as low bit counts of each block
`define SFSPI_ERASE_4K_BITS 12
`define SFSPI_ERASE_32K_BITS 15
`define SFSPI_ERASE_64K_BITS 16
`define SFSPI_PAGE_BITS 8
`define SFSPI_SECTOR_LSB 16
`define SFSPI_HALF_BIT 15

// default effective address width (top location 3FFFFF)
`define SFSPI_ADDR_BITS 22

`endif

// [hw/sfspi_pkg.sv]
// types of the serial flash command front end
package sfspi_pkg;

  // frame states, gray along opcode, address, dummy, data
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPCODE = 3'h1,
    ST_ADDR = 3'h3,
    ST_DUMMY = 3'h2,
    ST_DATA_OUT = 3'h6,
    ST_DATA_IN = 3'h7,
    ST_DONE = 3'h5,
    ST_IGNORE = 3'h4
  } sfspi_state_t;

  // number of data lines driven per clock
  typedef enum logic [1:0] {
    LANE_1 = 2'h0,
    LANE_2 = 2'h1,
    LANE_4 = 2'h2
  } sfspi_lanes_t;

  // erase granularity of a command
  typedef enum logic [2:0] {
    ERASE_NONE = 3'h0,
    ERASE_4K = 3'h1,
    ERASE_32K = 3'h2,
    ERASE_64K = 3'h3,
    ERASE_CHIP = 3'h4
  } sfspi_erase_t;

  // decoded opcode properties
  typedef struct packed {
    logic supported;
    logic has_addr;
    logic has_dummy;
    logic rd;
    logic wr;
    sfspi_lanes_t lanes;
    sfspi_erase_t erase;
  } sfspi_op_info_t;

endpackage : sfspi_pkg

// [hw/sfspi_sync.sv]
// two flip-flop synchroniser for the serial pins
`timescale 1ns/10ps
`default_nettype none

module sfspi_sync #(
  parameter int WIDTH = 6
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // first stage is read only by the second stage
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // reset parks both stages high, like a deselected bus with pull-ups
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule : sfspi_sync

`default_nettype wire

// [hw/sfspi_front_end.sv]
// serial command front end: framing, read lanes, address and geometry
`timescale 1ns/10ps
`default_nettype none
`include "sfspi_regs.svh"

module sfspi_front_end #(
  parameter int ADDR_BITS = `SFSPI_ADDR_BITS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] quad_data_lines_in,
  output logic [3:0] quad_data_lines_out,
  output logic [3:0] quad_data_lines_oe,
  output logic [ADDR_BITS-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic cmd_start,
  output logic [7:0] cmd_opcode,
  output logic [ADDR_BITS-1:0] cmd_addr,
  output sfspi_pkg::sfspi_erase_t cmd_erase,
  output logic [ADDR_BITS-1:0] cmd_erase_base,
  output logic [ADDR_BITS-17:0] cmd_sector,
  output logic cmd_half,
  output logic cmd_end,
  output logic cmd_abort,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic [ADDR_BITS-1:0] wr_addr
);

  localparam logic [ADDR_BITS-1:0] ADDR_ONE = ADDR_BITS'(1);

  // the sector and half split needs at least 17 address bits
  generate
    if (ADDR_BITS < 17 || ADDR_BITS > 24) begin : g_bad_width
      $error("ADDR_BITS must lie between 17 and 24");
    end
  endgenerate

  // opcode table lookup, used for the incoming and the held opcode
  function automatic sfspi_pkg::sfspi_op_info_t op_info(input logic [7:0] op);
    sfspi_pkg::sfspi_op_info_t info;
    info = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, sfspi_pkg::LANE_1, sfspi_pkg::ERASE_NONE};
    case (op)
      `SFSPI_OP_READ: info.rd = 1'b1;
      `SFSPI_OP_READ_FAST: begin
        info.rd = 1'b1;
        info.has_dummy = 1'b1;
      end
      `SFSPI_OP_READ_DUAL: begin
        info.rd = 1'b1;
        info.has_dummy = 1'b1;
        info.lanes = sfspi_pkg::LANE_2;
      end
      `SFSPI_OP_READ_QUAD: begin
        info.rd = 1'b1;
        info.has_dummy = 1'b1;
        info.lanes = sfspi_pkg::LANE_4;
      end
      `SFSPI_OP_ERASE_4K: info.erase = sfspi_pkg::ERASE_4K;
      `SFSPI_OP_ERASE_32K: info.erase = sfspi_pkg::ERASE_32K;
      `SFSPI_OP_ERASE_64K: info.erase = sfspi_pkg::ERASE_64K;
      `SFSPI_OP_ERASE_CHIP_A, `SFSPI_OP_ERASE_CHIP_B: begin
        info.has_addr = 1'b0;
        info.erase = sfspi_pkg::ERASE_CHIP;
      end
      `SFSPI_OP_PROGRAM: info.wr = 1'b1;
      `SFSPI_OP_WREN, `SFSPI_OP_WRDI: info.has_addr = 1'b0;
      default: begin
        info.supported = 1'b0;
        info.has_addr = 1'b0;
      end
    endcase
    return info;
  endfunction : op_info

  function automatic logic [ADDR_BITS-1:0] erase_base(input logic [ADDR_BITS-1:0] a,
                                                      input sfspi_pkg::sfspi_erase_t k);
    logic [ADDR_BITS-1:0] m;
    m = '1;
    unique case (k)
      sfspi_pkg::ERASE_4K: m = m << `SFSPI_ERASE_4K_BITS;
      sfspi_pkg::ERASE_32K: m = m << `SFSPI_ERASE_32K_BITS;
      sfspi_pkg::ERASE_64K: m = m << `SFSPI_ERASE_64K_BITS;
      sfspi_pkg::ERASE_CHIP: m = '0;
      default: m = '1;
    endcase
    return a & m;
  endfunction : erase_base

  // top bits of the byte go out first on the highest lane in use
  function automatic logic [3:0] lane_bits(input logic [7:0] b, input sfspi_pkg::sfspi_lanes_t l);
    unique case (l)
      sfspi_pkg::LANE_2: return {2'h0, b[7:6]};
      sfspi_pkg::LANE_4: return b[7:4];
      default: return {2'h0, b[7], 1'b0};
    endcase
  endfunction : lane_bits

  // enables for each width, only the serial output line in single mode
  function automatic logic [3:0] lane_oe(input sfspi_pkg::sfspi_lanes_t l);
    unique case (l)
      sfspi_pkg::LANE_2: return 4'h3;
      sfspi_pkg::LANE_4: return 4'hF;
      default: return 4'h2;
    endcase
  endfunction : lane_oe

  // shift distance, the bits moved per fall, for each width
  function automatic logic [2:0] lane_step(input sfspi_pkg::sfspi_lanes_t l);
    unique case (l)
      sfspi_pkg::LANE_2: return 3'h2;
      sfspi_pkg::LANE_4: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction : lane_step

  // all pins are foreign to core_clk, so each passes two flops
  logic [5:0] pins_s;
  sfspi_sync #(
    .WIDTH(6)
  ) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in({cs_n, sck, quad_data_lines_in}),
    .sync_out(pins_s)
  );

  logic cs_n_s; // synchronised select, high when deselected
  logic sck_s; // synchronised serial clock
  logic si_s; // serial input lane
  logic sck_d_r; // previous clock sample for edge finding
  logic sck_rise; // one-cycle pulse per rising edge
  logic sck_fall; // one-cycle pulse per falling edge
  assign cs_n_s = pins_s[5];
  assign sck_s = pins_s[4];
  assign si_s = pins_s[0];

  // edges come from sample pairs, so the idle level never counts as an edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      // same level as the synchroniser's reset, so no false edge follows reset
      sck_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
    end
  end
  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;

  // frame state and datapath
  sfspi_pkg::sfspi_state_t state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt; // edges within the current field
  logic [23:0] sh_r, sh_nxt; // incoming shift register
  logic [7:0] op_r, op_nxt; // held opcode
  sfspi_pkg::sfspi_lanes_t lanes_r, lanes_nxt; // width of the read phase
  logic [7:0] out_sh_r, out_sh_nxt; // outgoing byte, msb at the top
  logic [2:0] phase_r, phase_nxt; // falls left in the current out byte
  logic [ADDR_BITS-9:0] page_r, page_nxt; // page of a program stream
  logic [7:0] idx_r, idx_nxt; // byte inside that page
  logic [3:0] out_r, out_nxt;
  logic [3:0] oe_r, oe_nxt;
  logic [ADDR_BITS-1:0] rd_addr_r, rd_addr_nxt;
  logic start_r, start_nxt;
  logic [ADDR_BITS-1:0] addr_r, addr_nxt;
  sfspi_pkg::sfspi_erase_t erase_r, erase_nxt;
  logic [ADDR_BITS-1:0] ebase_r, ebase_nxt;
  logic end_r, end_nxt;
  logic abort_r, abort_nxt;
  logic wv_r, wv_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic [ADDR_BITS-1:0] wa_r, wa_nxt;
  sfspi_pkg::sfspi_op_info_t info_new; // decode of the opcode just completed
  sfspi_pkg::sfspi_op_info_t info_held; // decode of the held opcode
  logic [ADDR_BITS-1:0] addr_in_w; // address as completed, top bits dropped
  logic load_w; // a new read byte is fetched this cycle

  // built from the shift register and the live bit, so they never wait on sh_nxt;
  // only meaningful in a cycle with a rising edge, the only place they are used
  assign info_new = op_info({sh_r[6:0], si_s});
  assign info_held = op_info(op_r);
  // upper address bits fall away by truncation
  assign addr_in_w = {sh_r[ADDR_BITS-2:0], si_s};
  assign load_w = !cs_n_s && state_r == sfspi_pkg::ST_DATA_OUT && sck_fall && phase_r == 3'h0;

  // next-state logic for the whole frame
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    op_nxt = op_r;
    lanes_nxt = lanes_r;
    out_sh_nxt = out_sh_r;
    phase_nxt = phase_r;
    page_nxt = page_r;
    idx_nxt = idx_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    rd_addr_nxt = rd_addr_r;
    addr_nxt = addr_r;
    erase_nxt = erase_r;
    ebase_nxt = ebase_r;
    wd_nxt = wd_r;
    wa_nxt = wa_r;
    start_nxt = 1'b0;
    end_nxt = 1'b0;
    abort_nxt = 1'b0;
    wv_nxt = 1'b0;
    // every input bit is taken on a rising edge, msb first
    if (sck_rise) begin
      sh_nxt = {sh_r[22:0], si_s};
    end
    if (cs_n_s) begin
      // deselect closes the frame in any state
      state_nxt = sfspi_pkg::ST_IDLE;
      oe_nxt = 4'h0;
      // truncated frames only report an abort
      abort_nxt = state_r == sfspi_pkg::ST_OPCODE || state_r == sfspi_pkg::ST_ADDR;
      end_nxt = state_r == sfspi_pkg::ST_DUMMY || state_r == sfspi_pkg::ST_DATA_OUT ||
                state_r == sfspi_pkg::ST_DATA_IN || state_r == sfspi_pkg::ST_DONE;
    end else begin
      unique case (state_r)
        // a frame opens only once select is seen
        sfspi_pkg::ST_IDLE: begin
          state_nxt = sfspi_pkg::ST_OPCODE;
          cnt_nxt = 5'h00;
        end
        // eight rising edges form the opcode
        sfspi_pkg::ST_OPCODE: begin
          if (sck_rise) begin
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == `SFSPI_OPCODE_LAST) begin
              op_nxt = sh_nxt[7:0];
              lanes_nxt = info_new.lanes;
              cnt_nxt = 5'h00;
              if (!info_new.supported) begin
                state_nxt = sfspi_pkg::ST_IGNORE;
              end else if (info_new.has_addr) begin
                state_nxt = sfspi_pkg::ST_ADDR;
              end else begin
                // commands without address start right away
                state_nxt = sfspi_pkg::ST_DONE;
                start_nxt = 1'b1;
                erase_nxt = info_new.erase;
                addr_nxt = '0;
                ebase_nxt = '0;
              end
            end
          end
        end
        // twenty-four address bits follow the opcode
        sfspi_pkg::ST_ADDR: begin
          if (sck_rise) begin
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == `SFSPI_ADDR_LAST) begin
              cnt_nxt = 5'h00;
              phase_nxt = 3'h0;
              start_nxt = 1'b1;
              addr_nxt = addr_in_w;
              erase_nxt = info_held.erase;
              ebase_nxt = erase_base(addr_in_w, info_held.erase);
              rd_addr_nxt = addr_in_w;
              page_nxt = addr_in_w[ADDR_BITS-1:`SFSPI_PAGE_BITS];
              idx_nxt = addr_in_w[`SFSPI_PAGE_BITS-1:0];
              if (info_held.has_dummy) begin
                state_nxt = sfspi_pkg::ST_DUMMY;
              end else if (info_held.rd) begin
                state_nxt = sfspi_pkg::ST_DATA_OUT;
              end else if (info_held.wr) begin
                state_nxt = sfspi_pkg::ST_DATA_IN;
              end else begin
                state_nxt = sfspi_pkg::ST_DONE;
              end
            end
          end
        end
        // one dummy byte before fast and multi-line reads
        sfspi_pkg::ST_DUMMY: begin
          if (sck_rise) begin
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == `SFSPI_DUMMY_LAST) begin
              state_nxt = sfspi_pkg::ST_DATA_OUT;
            end
          end
        end
        // outputs move only on falling edges
        sfspi_pkg::ST_DATA_OUT: begin
          if (sck_fall) begin
            // dual read drives lines 1 and 0
            // quad read drives all four lines
            oe_nxt = lane_oe(lanes_r);
            if (phase_r == 3'h0) begin
              out_nxt = lane_bits(rd_data, lanes_r);
              out_sh_nxt = rd_data << lane_step(lanes_r);
              phase_nxt = (3'h7 / lane_step(lanes_r));
              // fetch address moves on, wrapping at the top
              rd_addr_nxt = rd_addr_r + ADDR_ONE;
            end else begin
              out_nxt = lane_bits(out_sh_r, lanes_r);
              out_sh_nxt = out_sh_r << lane_step(lanes_r);
              phase_nxt = phase_r - 3'h1;
            end
          end
        end
        // program data, one byte per eight rising edges
        sfspi_pkg::ST_DATA_IN: begin
          if (sck_rise) begin
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == `SFSPI_BYTE_LAST) begin
              cnt_nxt = 5'h00;
              wv_nxt = 1'b1;
              wd_nxt = sh_nxt[7:0];
              // byte index wraps inside the page
              wa_nxt = {page_r, idx_r};
              idx_nxt = idx_r + 8'h01;
            end
          end
        end
        // command complete, further bits have no meaning
        sfspi_pkg::ST_DONE: begin
          state_nxt = sfspi_pkg::ST_DONE;
        end
        sfspi_pkg::ST_IGNORE: begin
          state_nxt = sfspi_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  // register stage for the frame
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= sfspi_pkg::ST_IDLE;
      cnt_r <= 5'h00;
      sh_r <= 24'h000000;
      op_r <= 8'h00;
      lanes_r <= sfspi_pkg::LANE_1;
      out_sh_r <= 8'h00;
      phase_r <= 3'h0;
      page_r <= '0;
      idx_r <= 8'h00;
      out_r <= 4'h0;
      oe_r <= 4'h0;
      rd_addr_r <= '0;
      start_r <= 1'b0;
      addr_r <= '0;
      erase_r <= sfspi_pkg::ERASE_NONE;
      ebase_r <= '0;
      end_r <= 1'b0;
      abort_r <= 1'b0;
      wv_r <= 1'b0;
      wd_r <= 8'h00;
      wa_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      op_r <= op_nxt;
      lanes_r <= lanes_nxt;
      out_sh_r <= out_sh_nxt;
      phase_r <= phase_nxt;
      page_r <= page_nxt;
      idx_r <= idx_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      rd_addr_r <= rd_addr_nxt;
      start_r <= start_nxt;
      addr_r <= addr_nxt;
      erase_r <= erase_nxt;
      ebase_r <= ebase_nxt;
      end_r <= end_nxt;
      abort_r <= abort_nxt;
      wv_r <= wv_nxt;
      wd_r <= wd_nxt;
      wa_r <= wa_nxt;
    end
  end

  // outputs straight from flops
  assign quad_data_lines_out = out_r;
  assign quad_data_lines_oe = oe_r;
  assign rd_addr = rd_addr_r;
  assign cmd_start = start_r;
  assign cmd_opcode = op_r;
  assign cmd_addr = addr_r;
  assign cmd_erase = erase_r;
  assign cmd_erase_base = ebase_r;
  // sector number and half come from the held address
  assign cmd_sector = addr_r[ADDR_BITS-1:`SFSPI_SECTOR_LSB];
  assign cmd_half = addr_r[`SFSPI_HALF_BIT];
  assign cmd_end = end_r;
  assign cmd_abort = abort_r;
  assign wr_valid = wv_r;
  assign wr_data = wd_r;
  assign wr_addr = wa_r;

  // checks on the frame
  logic rd_msb; // helper for the msb check
  assign rd_msb = rd_data[7];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_last_op_bit;
    state_r == sfspi_pkg::ST_OPCODE && !cs_n_s && sck_rise && cnt_r == 5'h07;
  endsequence
  sequence s_last_addr_bit;
    state_r == sfspi_pkg::ST_ADDR && !cs_n_s && sck_rise && cnt_r == 5'h17;
  endsequence

  a_out_on_fall: assert property ($changed(out_r) |-> $past(sck_fall))
    else $error("output lines moved without a falling edge");
  a_opcode_width: assert property (s_last_op_bit |=> state_r != sfspi_pkg::ST_OPCODE)
    else $error("opcode phase did not end after eight bits");
  a_msb_first: assert property (load_w && lanes_r == sfspi_pkg::LANE_1 |=> out_r[1] == $past(rd_msb))
    else $error("first bit out is not the byte msb");
  a_deselect_idle: assert property (cs_n_s |=> state_r == sfspi_pkg::ST_IDLE)
    else $error("frame not closed on deselect");
  a_ignore_sticky: assert property (state_r == sfspi_pkg::ST_IGNORE && !cs_n_s |=> state_r == sfspi_pkg::ST_IGNORE && !start_r && !wv_r)
    else $error("ignored frame took action");
  a_trunc_abort: assert property (cs_n_s && (state_r == sfspi_pkg::ST_OPCODE || state_r == sfspi_pkg::ST_ADDR) |=> abort_r && !start_r && !end_r)
    else $error("truncated frame not aborted cleanly");
  a_addr_capture: assert property (s_last_addr_bit |=> start_r && addr_r == $past(addr_in_w))
    else $error("address not captured after 24 bits");
  a_addr_wrap: assert property (load_w && rd_addr_r == '1 |=> rd_addr_r == '0)
    else $error("read address did not wrap at the top");
  a_dual_lines: assert property (state_r == sfspi_pkg::ST_DATA_OUT && !cs_n_s && sck_fall && lanes_r == sfspi_pkg::LANE_2 |=> oe_r == 4'h3)
    else $error("dual read does not drive two lines");
  a_quad_lines: assert property (state_r == sfspi_pkg::ST_DATA_OUT && !cs_n_s && sck_fall && lanes_r == sfspi_pkg::LANE_4 |=> oe_r == 4'hF)
    else $error("quad read does not drive four lines");
  a_erase_align: assert property (start_r && erase_r == sfspi_pkg::ERASE_4K |-> ebase_r[11:0] == 12'h000)
    else $error("4k erase base not aligned");
  a_page_stay: assert property (wv_r |-> wa_r[ADDR_BITS-1:8] == addr_r[ADDR_BITS-1:8])
    else $error("program byte left its page");
  a_sector_split: assert property (start_r |-> cmd_sector == addr_r[ADDR_BITS-1:16] && cmd_half == addr_r[15])
    else $error("sector split wrong");
  a_so_release: assert property (cs_n_s |=> oe_r == 4'h0)
    else $error("lines driven while deselected");
  a_addr_advance: assert property (load_w |=> rd_addr_r == $past(rd_addr_r) + ADDR_ONE)
    else $error("read address did not advance");
  a_inputs_kept: assert property (oe_r != 4'h0 |-> state_r == sfspi_pkg::ST_DATA_OUT)
    else $error("lines driven outside the read phase");

endmodule : sfspi_front_end

`default_nettype wire

// [verification/sfsfe_host.sv]
// host spi master model: select, serial clock and serial input
`timescale 1ns/10ps
`default_nettype none

module sfsfe_host (
  input wire logic core_clk,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic [3:0] lines
);
  int seed = 38; // filler bits come from a fixed seed

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // half of the 400 ns serial clock, counted in core cycles so pins move on rising edges
  task automatic half_period;
    repeat (4) @(posedge core_clk);
  endtask : half_period

  // one frame of nt clocks; lines are sampled at the end of the high phase, well after launch
  task automatic frame(input logic [63:0] bits, input int nb, input int nt, input bit cpol,
                       output logic [63:0] cap);
    cap = 64'h0;
    sck <= cpol;
    half_period();
    cs_n <= 1'b0;
    half_period();
    for (int i = 0; i < nt; i++) begin
      sck <= 1'b0;
      si <= (i < nb) ? bits[63-i] : 1'($random(seed));
      half_period();
      sck <= 1'b1;
      half_period();
      cap = {cap[59:0], lines};
    end
    // back to idle level, then deselect
    sck <= cpol;
    half_period();
    cs_n <= 1'b1;
    si <= ~si; // released line must not keep its last value
  endtask : frame
endmodule : sfsfe_host
`default_nettype wire

// [verification/serial_flash_spi_front_end_tb.sv]
// self-checking bench of the serial flash command front end
`timescale 1ns/10ps
`default_nettype none

module serial_flash_spi_front_end_tb;
  typedef struct {logic [3:0] k; logic [63:0] v; logic [63:0] m;} sfsfe_note_t;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n, sck, si, cmd_start, cmd_half, cmd_end, cmd_abort, wr_valid;
  logic [3:0] qin, qout, qoe;
  logic [21:0] rd_addr, cmd_addr, cmd_erase_base, wr_addr;
  logic [5:0] cmd_sector;
  logic [7:0] rd_data, cmd_opcode, wr_data;
  sfspi_pkg::sfspi_erase_t cmd_erase;
  int err_total = 0;
  int checks = 0;
  int seed = 38;
  sfsfe_note_t q[$]; // expected events, oldest first
  sfsfe_note_t n;
  logic [7:0] ops[7] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h06, 8'h04};
  logic [7:0] rop[4] = '{8'h03, 8'h0B, 8'h3B, 8'h6B};
  int rdum[4] = '{0, 8, 8, 8};
  int rw[4] = '{1, 1, 2, 4};

  always #25 core_clk = ~core_clk;

  // array byte pattern, answered in the same cycle
  function automatic logic [7:0] pat(input logic [21:0] a);
    return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]};
  endfunction : pat
  assign rd_data = pat(rd_addr);
  // pin levels from enables; write-lock and pause lines are pulled up
  assign qin[0] = qoe[0] ? qout[0] : si;
  assign qin[1] = qoe[1] ? qout[1] : ~qout[1];
  assign qin[3:2] = qout[3:2] | ~qoe[3:2];
  wire [63:0] got = cmd_start ?
    {cmd_opcode, cmd_addr, cmd_erase, cmd_erase_base, cmd_sector, cmd_half, 2'h0} :
    {wr_data, wr_addr, 34'h0};

  sfspi_front_end i_sfspi_front_end (.core_clk(core_clk), .reset(reset), .cs_n(cs_n),
    .sck(sck), .quad_data_lines_in(qin), .quad_data_lines_out(qout),
    .quad_data_lines_oe(qoe), .rd_addr(rd_addr), .rd_data(rd_data), .cmd_start(cmd_start),
    .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_erase(cmd_erase),
    .cmd_erase_base(cmd_erase_base), .cmd_sector(cmd_sector), .cmd_half(cmd_half),
    .cmd_end(cmd_end), .cmd_abort(cmd_abort), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_addr(wr_addr));
  sfsfe_host i_sfsfe_host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si), .lines(qin));

  task automatic fail(input string s);
    err_total++;
    $display("[FAIL] %0t %s", $time, s);
  endtask : fail

  task automatic give_verdict;
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic note(input logic [3:0] k, input logic [63:0] v, input logic [63:0] m);
    q.push_back('{k, v, m});
  endtask : note

  // start note; base is only compared for erase commands
  task automatic exp_cmd(input logic [7:0] op, input logic [23:0] ad, input bit adr);
    logic [21:0] a, msk;
    logic [2:0] e;
    a = adr ? ad[21:0] : 22'h0;
    case (op)
      8'h20: e = 3'h1;
      8'h52: e = 3'h2;
      8'hD8: e = 3'h3;
      8'h60, 8'hC7: e = 3'h4;
      default: e = 3'h0;
    endcase
    msk = (e == 3'h1) ? 22'h3FF000 : (e == 3'h2) ? 22'h3F8000 :
          (e == 3'h3) ? 22'h3F0000 : 22'h0;
    note(4'h8, {op, a, e, a & msk, a[21:16], a[15], 2'h0},
         {33'h1FFFFFFFF, {22{e != 3'h0}}, 9'h1FF});
  endtask : exp_cmd

  // two bytes rebuilt from the last samples, highest line first
  function automatic logic [15:0] bytes(input logic [63:0] c, input int w);
    logic [15:0] v;
    logic [3:0] t;
    v = 16'h0;
    for (int s = 16 / w - 1; s >= 0; s--) begin
      t = c[4*s+:4];
      v = (v << w) | 16'((w == 1) ? 4'(t[1]) : (w == 2) ? 4'(t[1:0]) : t);
    end
    return v;
  endfunction : bytes

  // one frame off the core clock phase, then lines and notes must be settled
  task automatic run(input logic [63:0] b, input int nb, input int nt, input bit cp,
                     output logic [63:0] cap);
    @(posedge core_clk);
    i_sfsfe_host.frame(b, nb, nt, cp, cap);
    repeat (6) @(posedge core_clk);
    checks++;
    if (qoe !== 4'h0 || q.size() != 0) fail("lines driven or event missing");
  endtask : run

  // every pulse takes the oldest note
  always @(posedge core_clk) begin
    if (!reset && (cmd_start || cmd_abort || wr_valid || cmd_end)) begin
      checks++;
      if (q.size() == 0) fail("event with no note");
      else begin
        n = q.pop_front();
        if (n.k !== {cmd_start, cmd_abort, wr_valid, cmd_end} || (got & n.m) !== (n.v & n.m))
          fail("event mismatch");
      end
    end
  end

  initial begin
    logic [63:0] cap;
    logic [23:0] ad;
    logic [7:0] d1, d2;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    // erase and plain commands, idle level alternating
    foreach (ops[i]) begin
      ad = 24'($random(seed));
      exp_cmd(ops[i], ad, i < 3);
      note(4'h1, 64'h0, 64'h0);
      run({ops[i], ad, 32'h0}, (i < 3) ? 32 : 8, (i < 3) ? 32 : 8, i[0], cap);
    end
    // reads on one, two and four lanes, two bytes each
    foreach (rop[i]) begin
      ad = 24'($random(seed));
      if (i == 0) ad = 24'hFFFFFF; // top of the array wraps to zero
      exp_cmd(rop[i], ad, 1'b1);
      note(4'h1, 64'h0, 64'h0);
      run({rop[i], ad, 32'h0}, 32, 32 + rdum[i] + 16 / rw[i], i[0], cap);
      checks++;
      if (bytes(cap, rw[i]) !== {pat(ad[21:0]), pat(ad[21:0] + 22'h1)})
        fail("read data");
    end
    // program from the last byte of a page wraps to its start
    ad = 24'($random(seed));
    ad[7:0] = 8'hFF;
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    exp_cmd(8'h02, ad, 1'b1);
    note(4'h2, {d1, ad[21:0], 34'h0}, '1);
    note(4'h2, {d2, ad[21:8], 8'h00, 34'h0}, '1);
    note(4'h1, 64'h0, 64'h0);
    run({8'h02, ad, d1, d2, 16'h0}, 48, 48, 1'b0, cap);
    // unknown opcode followed by a valid one stays silent
    run({8'h9F, 8'h06, 48'h0}, 16, 40, 1'b0, cap);
    // deselect inside the address, then inside the opcode
    note(4'h4, 64'h0, 64'h0);
    run({8'h03, 56'h0}, 8, 20, 1'b1, cap);
    note(4'h4, 64'h0, 64'h0);
    run(64'h0, 0, 5, 1'b0, cap);
    give_verdict();
  end

  // watchdog well beyond the expected run of about 190 us
  initial begin
    #1000000;
    err_total++;
    give_verdict();
  end
endmodule : serial_flash_spi_front_end_tb
`default_nettype wire
